// *** drive_parameter_access_manager.sv ***
// Parameter access manager with one access state machine per connection
`include "drive_access_regs.svh"
`default_nettype none
// Behaviour
// RULE1 - Client delivers a request by writing the whole request structure.
// RULE2 - Write completed while idle starts processing and enters the busy state.
// RULE3 - Write refused when busy or down; write discards a ready response.
// RULE4 - Client fetches the result by reading the response structure back.
// RULE5 - Read gives ready response then idle; refused when idle or down.
// RULE6 - Each machine serves one connection, unaffected by other connections.
// RULE7 - One independent access machine is kept per connection.
// RULE8 - Header: reference and identifier at 0, object and count at 2.
// RULE9 - Address block at 4; element count 0 for single access; value at 10.
// RULE10 - Read answer: format and count at 4, value at 6, ends 8 or 10.
// RULE11 - Answers mirror reference and object; errors carry one 16-bit value.
// RULE12 - Set-up enters idle, loss aborts, completion makes response ready.
// RULE13 - Address, type, format or count errors cancel all changes of request.
// RULE14 - Byte, word and double word supported; mismatched write type refused.
module drive_parameter_access_manager (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic [`NUM_CONN-1:0]     conn_up,
  input  wire logic [`NUM_CONN-1:0]     conn_down,
  input  wire logic [`NUM_CONN-1:0]     wr_req,
  input  wire logic [`NUM_CONN-1:0]     rd_req,
  input  wire drive_access_pkg::req_s   req_data   [`NUM_CONN],
  output var  drive_access_pkg::reply_s reply      [`NUM_CONN],
  output var  drive_access_pkg::resp_s  resp_data  [`NUM_CONN],
  output var  drive_access_pkg::state_e conn_state [`NUM_CONN]
);

  logic [`NUM_CONN-1:0]     start;
  logic [`NUM_CONN-1:0]     abort;
  logic [`NUM_CONN-1:0]     pend_reg;
  logic [`NUM_CONN-1:0]     pend_next;
  logic [`NUM_CONN-1:0]     done_reg;
  logic [`NUM_CONN-1:0]     done_next;
  drive_access_pkg::req_s   req_reg   [`NUM_CONN];
  drive_access_pkg::req_s   req_next  [`NUM_CONN];
  drive_access_pkg::resp_s  resp_reg  [`NUM_CONN];
  drive_access_pkg::resp_s  resp_next [`NUM_CONN];
  logic [31:0]              val_reg   [`PARAM_DEPTH];
  logic [31:0]              val_next  [`PARAM_DEPTH];
  logic                     found;
  logic [`CONN_IDX_W-1:0]   sel;
  drive_access_pkg::req_s   cur;
  drive_access_pkg::resp_s  resp;
  logic [`PARAM_IDX_W-1:0]  idx;
  logic [7:0]               fmt_exp;
  logic                     err;
  logic [15:0]              err_val;
  logic [31:0]              wr_val;

  // Fixed data type of each parameter slot
  function automatic logic [7:0] fmt_of(input logic [`PARAM_IDX_W-1:0] i);
    case (i[1:0])
      2'h0:    fmt_of = `FMT_BYTE;
      2'h1:    fmt_of = `FMT_WORD;
      default: fmt_of = `FMT_DWORD;
    endcase
  endfunction

  // One independent access machine per connection
  generate
    for (genvar c = 0; c < `NUM_CONN; c++) begin : g_conn
      access_fsm u_fsm ( // see RULE7
        .clk       (clk),
        .rst       (rst),
        .conn_up   (conn_up[c]),
        .conn_down (conn_down[c]),
        .wr_req    (wr_req[c]),
        .rd_req    (rd_req[c]),
        .proc_done (done_reg[c]),
        .state     (conn_state[c]),
        .start     (start[c]),
        .abort     (abort[c]),
        .reply     (reply[c])
      );
    end
  endgenerate

  // Processing engine: serves the lowest pending connection each cycle
  always_comb begin
    found = 1'b0;
    sel   = '0;
    for (int i = `NUM_CONN - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        found = 1'b1;
        sel   = `CONN_IDX_W'(i);
      end
    end
    cur     = req_reg[sel];
    idx     = cur.pnum[`PARAM_IDX_W-1:0];
    fmt_exp = fmt_of(idx);
    err     = 1'b1;
    err_val = `ERR_ADDR; // see RULE9
    if ((cur.req_id != `ID_READ && cur.req_id != `ID_CHANGE) || cur.num_par != 8'h01
        || cur.num_elem != 8'h00 || cur.pnum >= 16'(`PARAM_DEPTH)) begin
      err = 1'b1;
    end else if (cur.req_id == `ID_CHANGE && cur.fmt != `FMT_BYTE && cur.fmt != `FMT_WORD
                 && cur.fmt != `FMT_DWORD) begin
      err_val = `ERR_FMT;
    end else if (cur.req_id == `ID_CHANGE && cur.fmt != fmt_exp) begin
      err_val = `ERR_TYPE; // see RULE14
    end else if (cur.req_id == `ID_CHANGE && cur.num_val != 8'h01) begin
      err_val = `ERR_NVAL;
    end else begin
      err = 1'b0;
    end
    // Mirror reference, object and count
    resp         = '0;
    resp.ref_num = cur.ref_num; // see RULE11
    resp.obj_id  = cur.obj_id; // see RULE8
    resp.num_par = cur.num_par;
    if (err) begin
      resp.resp_id = cur.req_id | `ID_NEG_BIT; // see RULE11
      resp.fmt     = `FMT_ERROR;
      resp.num_val = 8'h01;
      resp.value   = {16'h0000, err_val};
      resp.length  = `LEN_WORD;
    end else if (cur.req_id == `ID_READ) begin
      resp.resp_id = cur.req_id; // see RULE10
      resp.fmt     = fmt_exp;
      resp.num_val = 8'h01;
      resp.value   = val_reg[idx];
      resp.length  = (fmt_exp == `FMT_DWORD) ? `LEN_DWORD : `LEN_WORD;
    end else begin
      resp.resp_id = cur.req_id; // see RULE11
      resp.length  = `LEN_HEADER;
    end
    // Value trimmed to the parameter's width
    case (fmt_exp)
      `FMT_BYTE: wr_val = {24'h000000, cur.value[7:0]};
      `FMT_WORD: wr_val = {16'h0000, cur.value[15:0]};
      default:   wr_val = cur.value;
    endcase
  end

  // Next values of request latches, pending flags, responses and store
  always_comb begin
    pend_next = pend_reg;
    done_next = '0;
    req_next  = req_reg;
    resp_next = resp_reg;
    val_next  = val_reg;
    for (int i = 0; i < `NUM_CONN; i++) begin
      if (abort[i]) begin
        pend_next[i] = 1'b0; // see RULE12
      end else if (start[i]) begin
        pend_next[i] = 1'b1; // see RULE2
        req_next[i]  = req_data[i]; // see RULE1
      end else if (found && sel == `CONN_IDX_W'(i)) begin
        pend_next[i] = 1'b0;
        done_next[i] = 1'b1;
        resp_next[i] = resp; // see RULE4
      end
    end
    // A failing change writes nothing, so no partial update survives
    if (found && !err && cur.req_id == `ID_CHANGE && !abort[sel]) begin
      val_next[idx] = wr_val; // see RULE13
    end
  end

  // Registers of the engine and the parameter store
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_reg <= '0;
      done_reg <= '0;
      for (int i = 0; i < `NUM_CONN; i++) begin
        req_reg[i]  <= '0;
        resp_reg[i] <= '0;
      end
      for (int j = 0; j < `PARAM_DEPTH; j++) begin
        val_reg[j] <= '0;
      end
    end else begin
      pend_reg <= pend_next;
      done_reg <= done_next;
      req_reg  <= req_next;
      resp_reg <= resp_next;
      val_reg  <= val_next;
    end
  end

  assign resp_data = resp_reg;

  property p_mirror;
    @(posedge clk) disable iff (rst)
    done_reg[0] |-> resp_data[0].ref_num == req_reg[0].ref_num
                    && resp_data[0].obj_id == req_reg[0].obj_id;
  endproperty
  a_mirror: assert property (p_mirror) else $error("Response does not mirror request"); // see RULE11

  property p_neg_len;
    @(posedge clk) disable iff (rst)
    done_reg[0] && resp_data[0].resp_id[7] |-> resp_data[0].fmt == `FMT_ERROR
      && resp_data[0].num_val == 8'h01 && resp_data[0].length == `LEN_WORD;
  endproperty
  a_neg_len: assert property (p_neg_len) else $error("Negative response malformed"); // see RULE11

  property p_rd_len;
    @(posedge clk) disable iff (rst)
    done_reg[0] && resp_data[0].resp_id == `ID_READ |->
      resp_data[0].length == ((resp_data[0].fmt == `FMT_DWORD) ? `LEN_DWORD : `LEN_WORD);
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("Read response length wrong"); // see RULE10

  property p_isolate;
    @(posedge clk) disable iff (rst)
    !conn_up[1] && !conn_down[1] && !wr_req[1] && !rd_req[1] && !done_reg[1]
      |=> $stable(conn_state[1]);
  endproperty
  a_isolate: assert property (p_isolate) else $error("Connection state moved without own event"); // see RULE6

  property p_no_write_on_err;
    @(posedge clk) disable iff (rst)
    found && err |-> val_next[idx] == val_reg[idx];
  endproperty
  a_no_write_on_err: assert property (p_no_write_on_err) else $error("Failed change altered value"); // see RULE13

endmodule
`default_nettype wire

// *** drive_access_regs.svh ***
// Constants of the drive parameter access manager
`ifndef DRIVE_ACCESS_REGS_SVH
`define DRIVE_ACCESS_REGS_SVH

`define NUM_CONN      2
`define CONN_IDX_W    1
`define PARAM_DEPTH   16
`define PARAM_IDX_W   4

// Byte offsets inside a telegram
`define OFS_HEADER    8'h00
`define OFS_OBJECT    8'h02
`define OFS_ADDRESS   8'h04
`define OFS_VALUE_RD  8'h06
`define OFS_VALUE_WR  8'h0a

// Request and response identifiers
`define ID_READ       8'h01
`define ID_CHANGE     8'h02
`define ID_NEG_BIT    8'h80

// Value formats
`define FMT_BYTE      8'h41
`define FMT_WORD      8'h42
`define FMT_DWORD     8'h43
`define FMT_ERROR     8'h44

// Error values
`define ERR_TYPE      16'h0005
`define ERR_ADDR      16'h0016
`define ERR_FMT       16'h0017
`define ERR_NVAL      16'h0018

// Response lengths in bytes
`define LEN_HEADER    8'h04
`define LEN_WORD      8'h08
`define LEN_DWORD     8'h0a

`endif

// *** drive_access_pkg.sv ***
// Types shared by the drive parameter access manager
`default_nettype none
package drive_access_pkg;

  typedef enum logic [1:0] {CONN_LOST, IDLE, BUSY, RESP_READY} state_e;

  typedef enum logic [1:0] {CODE_NONE, CODE_CONFLICT, CODE_PROTOCOL} reply_code_e;

  // Request telegram, fields in byte-offset order
  typedef struct packed {
    logic [7:0]  ref_num;
    logic [7:0]  req_id;
    logic [7:0]  obj_id;
    logic [7:0]  num_par;
    logic [7:0]  attr;
    logic [7:0]  num_elem;
    logic [15:0] pnum;
    logic [15:0] subidx;
    logic [7:0]  fmt;
    logic [7:0]  num_val;
    logic [31:0] value;
  } req_s;

  // Response telegram with its byte length
  typedef struct packed {
    logic [7:0]  ref_num;
    logic [7:0]  resp_id;
    logic [7:0]  obj_id;
    logic [7:0]  num_par;
    logic [7:0]  fmt;
    logic [7:0]  num_val;
    logic [31:0] value;
    logic [7:0]  length;
  } resp_s;

  // Reply to the client for one cycle
  typedef struct packed {
    logic        wr_ack;
    logic        rd_ack;
    logic        positive;
    reply_code_e code;
    logic        done_rej;
    logic        internal_err;
  } reply_s;

endpackage
`default_nettype wire

// *** access_fsm.sv ***
// Access state machine serving one client connection
`default_nettype none
module access_fsm (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     conn_up,
  input  wire logic                     conn_down,
  input  wire logic                     wr_req,
  input  wire logic                     rd_req,
  input  wire logic                     proc_done,
  output var  drive_access_pkg::state_e state,
  output logic                          start,
  output logic                          abort,
  output var  drive_access_pkg::reply_s reply
);

  drive_access_pkg::state_e state_reg;
  drive_access_pkg::state_e state_next;
  drive_access_pkg::reply_s reply_reg;
  drive_access_pkg::reply_s reply_next;

  // Next state and reply from the event and current state
  always_comb begin
    state_next = state_reg;
    reply_next = '0;
    start      = 1'b0;
    abort      = 1'b0;
    if (conn_down) begin
      if (state_reg != drive_access_pkg::CONN_LOST) begin
        abort      = 1'b1; // see RULE12
        state_next = drive_access_pkg::CONN_LOST;
      end
    end else if (conn_up) begin
      abort      = 1'b1; // see RULE12
      state_next = drive_access_pkg::IDLE;
    end else begin
      if (wr_req) begin
        reply_next.wr_ack = 1'b1;
        case (state_reg)
          drive_access_pkg::CONN_LOST: reply_next.code = drive_access_pkg::CODE_PROTOCOL; // see RULE3
          drive_access_pkg::BUSY:      reply_next.code = drive_access_pkg::CODE_CONFLICT; // see RULE3
          drive_access_pkg::IDLE, drive_access_pkg::RESP_READY: begin
            reply_next.positive = 1'b1; // see RULE2
            start      = 1'b1;
            state_next = drive_access_pkg::BUSY;
          end
          default: reply_next.code = drive_access_pkg::CODE_PROTOCOL;
        endcase
      end else if (rd_req) begin
        reply_next.rd_ack = 1'b1;
        case (state_reg)
          drive_access_pkg::CONN_LOST: reply_next.code = drive_access_pkg::CODE_PROTOCOL; // see RULE5
          drive_access_pkg::RESP_READY: begin
            reply_next.positive = 1'b1; // see RULE5
            state_next = drive_access_pkg::IDLE;
          end
          default: reply_next.code = drive_access_pkg::CODE_CONFLICT; // see RULE5
        endcase
      end
      if (proc_done) begin
        if (state_reg == drive_access_pkg::BUSY) begin
          state_next = drive_access_pkg::RESP_READY; // see RULE12
        end else begin
          reply_next.done_rej     = 1'b1;
          reply_next.internal_err = (state_reg == drive_access_pkg::RESP_READY);
        end
      end
    end
  end

  // State and reply registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= drive_access_pkg::CONN_LOST;
      reply_reg <= '0;
    end else begin
      state_reg <= state_next;
      reply_reg <= reply_next;
    end
  end

  assign state = state_reg;
  assign reply = reply_reg;

  sequence s_quiet;
    !conn_down && !conn_up;
  endsequence

  property p_wr_idle;
    @(posedge clk) disable iff (rst)
    s_quiet ##0 (wr_req && state_reg == drive_access_pkg::IDLE)
      |=> state_reg == drive_access_pkg::BUSY && reply.wr_ack && reply.positive;
  endproperty
  a_wr_idle: assert property (p_wr_idle) else $error("Idle write did not start processing"); // see RULE2

  property p_wr_busy;
    @(posedge clk) disable iff (rst)
    s_quiet ##0 (wr_req && !proc_done && state_reg == drive_access_pkg::BUSY)
      |=> state_reg == drive_access_pkg::BUSY && !reply.positive
          && reply.code == drive_access_pkg::CODE_CONFLICT;
  endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("Busy write not refused"); // see RULE3

  property p_wr_lost;
    @(posedge clk) disable iff (rst)
    s_quiet ##0 (wr_req && state_reg == drive_access_pkg::CONN_LOST)
      |=> reply.code == drive_access_pkg::CODE_PROTOCOL && $stable(state_reg);
  endproperty
  a_wr_lost: assert property (p_wr_lost) else $error("Write while down not a protocol error"); // see RULE3

  property p_rd_ready;
    @(posedge clk) disable iff (rst)
    s_quiet ##0 (rd_req && !wr_req && state_reg == drive_access_pkg::RESP_READY)
      |=> reply.rd_ack && reply.positive && state_reg == drive_access_pkg::IDLE;
  endproperty
  a_rd_ready: assert property (p_rd_ready) else $error("Read of response did not return to idle"); // see RULE5

  property p_rd_idle;
    @(posedge clk) disable iff (rst)
    s_quiet ##0 (rd_req && !wr_req && state_reg == drive_access_pkg::IDLE)
      |=> !reply.positive && reply.code == drive_access_pkg::CODE_CONFLICT;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("Idle read not refused"); // see RULE5

  property p_down;
    @(posedge clk) disable iff (rst)
    conn_down |-> (abort || state_reg == drive_access_pkg::CONN_LOST)
      ##1 state_reg == drive_access_pkg::CONN_LOST;
  endproperty
  a_down: assert property (p_down) else $error("Connection loss not entered"); // see RULE12

  property p_done_ready;
    @(posedge clk) disable iff (rst)
    s_quiet ##0 (proc_done && state_reg == drive_access_pkg::RESP_READY)
      |=> reply.done_rej && reply.internal_err;
  endproperty
  a_done_ready: assert property (p_done_ready) else $error("Second completion not flagged"); // see RULE12

endmodule
`default_nettype wire

// *** client_model.sv ***
// Controller client model driving one connection of the access manager
`default_nettype none
module client_model (
  input  wire logic                   clk,
  output logic                        up,
  output logic                        down,
  output logic                        wr,
  output logic                        rd,
  output var drive_access_pkg::req_s  req
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle lines at time zero
  initial begin
    up = 1'b0;
    down = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    req = '0;
  end

  // Connection set-up or loss as a one-cycle event
  task automatic conn(input logic u);
    @(negedge clk);
    up = u;
    down = !u;
    @(negedge clk);
    up = 1'b0;
    down = 1'b0;
  endtask

  // Whole telegram held with the write, then garbled once released
  task automatic write_ds(input drive_access_pkg::req_s r, input int n);
    @(negedge clk);
    wr = 1'b1;
    req = r;
    repeat (n) @(negedge clk);
    wr = 1'b0;
    req = ~r;
  endtask

  // Response fetched by a read of the same data set
  task automatic read_ds;
    @(negedge clk);
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the drive parameter access manager
`include "drive_access_regs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic                     clk;
  logic                     rst;
  int                       failures;
  int                       checks;
  wire  [1:0]               up_w;
  wire  [1:0]               down_w;
  wire  [1:0]               wr_w;
  wire  [1:0]               rd_w;
  wire  drive_access_pkg::req_s req_w [2];
  drive_access_pkg::reply_s reply_w [2];
  drive_access_pkg::resp_s  resp_w [2];
  drive_access_pkg::state_e st_w [2];
  drive_access_pkg::reply_s got [$];
  drive_access_pkg::resp_s  rs;

  // Free running clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // One client per connection
  for (genvar g = 0; g < 2; g++) begin : cl
    client_model client_model_i (
      .clk  (clk),
      .up   (up_w[g]),
      .down (down_w[g]),
      .wr   (wr_w[g]),
      .rd   (rd_w[g]),
      .req  (req_w[g])
    );
  end

  drive_parameter_access_manager drive_parameter_access_manager_i (
    .clk        (clk),
    .rst        (rst),
    .conn_up    (up_w),
    .conn_down  (down_w),
    .wr_req     (wr_w),
    .rd_req     (rd_w),
    .req_data   (req_w),
    .reply      (reply_w),
    .resp_data  (resp_w),
    .conn_state (st_w)
  );

  // Verdict and end of run
  task automatic close_out;
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Compare one value and count it
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("FAIL at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask

  // Compare the first gathered reply
  task automatic crep(input logic w, input logic p, input drive_access_pkg::reply_code_e c);
    drive_access_pkg::reply_s e;
    e = '0;
    e.wr_ack = w;
    e.rd_ack = !w;
    e.positive = p;
    e.code = c;
    chk(32'(got[0]), 32'(e));
  endtask

  // Build a single-parameter telegram
  function automatic drive_access_pkg::req_s mk(input logic [7:0] r, input logic [7:0] id,
                                                input logic [15:0] pn, input logic [7:0] f,
                                                input logic [31:0] v);
    mk = '0;
    mk.ref_num = r;
    mk.req_id = id;
    mk.obj_id = 8'h03;
    mk.num_par = 8'h01;
    mk.attr = 8'h10;
    mk.pnum = pn;
    mk.fmt = f;
    mk.num_val = {7'h0, id == `ID_CHANGE};
    mk.value = v;
  endfunction

  // One write or read on connection 0, gathering its replies
  task automatic xfer(input logic w, input drive_access_pkg::req_s r, input int n);
    got.delete();
    fork
      if (w) cl[0].client_model_i.write_ds(r, n);
      else cl[0].client_model_i.read_ds();
      repeat (n + 4) begin
        @(negedge clk);
        if (reply_w[0].wr_ack === 1'b1 || reply_w[0].rd_ack === 1'b1) got.push_back(reply_w[0]);
      end
    join
  endtask

  // Bounded wait for a state on connection 0
  task automatic wait_st(input drive_access_pkg::state_e s);
    for (int i = 0; i < 20 && st_w[0] !== s; i++) @(negedge clk);
    if (st_w[0] !== s) begin
      failures++;
      $display("FAIL at %0t ns: got %h expected %h", $time, st_w[0], s);
      close_out();
    end
  endtask

  // Full request and response round trip
  task automatic run(input drive_access_pkg::req_s r);
    xfer(1'b1, r, 1);
    crep(1'b1, 1'b1, drive_access_pkg::CODE_NONE);
    wait_st(drive_access_pkg::RESP_READY);
    xfer(1'b0, r, 1);
    crep(1'b0, 1'b1, drive_access_pkg::CODE_NONE);
    rs = resp_w[0];
  endtask

  // Traffic before set-up is refused
  task automatic s_lost;
    xfer(1'b1, mk(8'h11, `ID_READ, 16'h0001, 8'h00, 32'h0), 1);
    crep(1'b1, 1'b0, drive_access_pkg::CODE_PROTOCOL);
    xfer(1'b0, '0, 1);
    crep(1'b0, 1'b0, drive_access_pkg::CODE_PROTOCOL);
    chk(32'(st_w[0]), 32'(drive_access_pkg::CONN_LOST));
  endtask

  // Set-up, then a read with nothing pending
  task automatic s_setup;
    cl[0].client_model_i.conn(1'b1);
    cl[1].client_model_i.conn(1'b1);
    wait_st(drive_access_pkg::IDLE);
    chk(32'(st_w[1]), 32'(drive_access_pkg::IDLE));
    xfer(1'b0, '0, 1);
    crep(1'b0, 1'b0, drive_access_pkg::CODE_CONFLICT);
  endtask

  // Back-to-back writes, the second meets a busy machine
  task automatic s_change;
    xfer(1'b1, mk(8'h21, `ID_CHANGE, 16'h0001, `FMT_WORD, 32'h00001234), 2);
    chk(32'(got.size()), 32'h2);
    crep(1'b1, 1'b1, drive_access_pkg::CODE_NONE);
    got.delete(0);
    crep(1'b1, 1'b0, drive_access_pkg::CODE_CONFLICT);
    wait_st(drive_access_pkg::RESP_READY);
    xfer(1'b0, '0, 1);
    rs = resp_w[0];
    chk({rs.ref_num, rs.resp_id, rs.obj_id, rs.num_par}, 32'h21020301);
    chk(32'(rs.length), 32'(`LEN_HEADER));
    chk(32'(st_w[0]), 32'(drive_access_pkg::IDLE));
    chk(32'(st_w[1]), 32'(drive_access_pkg::IDLE));
  endtask

  // Change then read back each data type
  task automatic s_reads;
    logic [7:0]  f [3] = '{`FMT_BYTE, `FMT_WORD, `FMT_DWORD};
    logic [31:0] v [3] = '{32'h0000005a, 32'h0000a55a, 32'hdeadbeef};
    logic [7:0]  l [3] = '{`LEN_WORD, `LEN_WORD, `LEN_DWORD};
    for (int i = 0; i < 3; i++) begin
      run(mk(8'h40, `ID_CHANGE, 16'(i), f[i], v[i]));
      run(mk(8'h50, `ID_READ, 16'(i), 8'h00, 32'h0));
      chk({8'h0, rs.fmt, rs.num_val, rs.length}, {8'h0, f[i], 8'h01, l[i]});
      chk(rs.value, v[i]);
    end
  endtask

  // Faulty changes give error answers and leave the slot alone
  task automatic s_errors;
    drive_access_pkg::req_s r [4];
    logic [15:0] e [4] = '{`ERR_ADDR, `ERR_TYPE, `ERR_FMT, `ERR_NVAL};
    for (int i = 0; i < 4; i++) r[i] = mk(8'h60, `ID_CHANGE, 16'h0001, `FMT_WORD, 32'h0bad);
    r[0].num_elem = 8'h05;
    r[1].fmt = `FMT_DWORD;
    r[2].fmt = 8'h99;
    r[3].num_val = 8'h02;
    for (int i = 0; i < 4; i++) begin
      run(r[i]);
      chk({rs.resp_id, rs.fmt, rs.num_val, rs.length}, {8'h82, `FMT_ERROR, 8'h01, `LEN_WORD});
      chk(32'(rs.value[15:0]), 32'(e[i]));
    end
    run(mk(8'h61, `ID_READ, 16'h0001, 8'h00, 32'h0));
    chk(rs.value, 32'h0000a55a);
  endtask

  // A new write discards a pending response, then a loss aborts
  task automatic s_restart;
    xfer(1'b1, mk(8'h71, `ID_READ, 16'h0001, 8'h00, 32'h0), 1);
    wait_st(drive_access_pkg::RESP_READY);
    run(mk(8'h72, `ID_READ, 16'h0002, 8'h00, 32'h0));
    chk({rs.ref_num, 24'h0}, {8'h72, 24'h0});
    cl[0].client_model_i.write_ds(mk(8'h81, `ID_READ, 16'h0001, 8'h00, 32'h0), 1);
    chk(32'(st_w[0]), 32'(drive_access_pkg::BUSY));
    cl[0].client_model_i.conn(1'b0);
    chk(32'(st_w[0]), 32'(drive_access_pkg::CONN_LOST));
    chk(32'(st_w[1]), 32'(drive_access_pkg::IDLE));
    cl[0].client_model_i.conn(1'b1);
    wait_st(drive_access_pkg::IDLE);
    xfer(1'b0, '0, 1);
    crep(1'b0, 1'b0, drive_access_pkg::CODE_CONFLICT);
  endtask

  // Reset, then the scenarios in turn
  initial begin
    failures = 0;
    checks = 0;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    s_lost();
    s_setup();
    s_change();
    s_reads();
    s_errors();
    s_restart();
    close_out();
  end
endmodule
`default_nettype wire
